// file: inc/chf_pkg.sv
package chf_pkg;

  // register map on the plain 8-bit port
  localparam logic [7:0] OFS_STATUS      = 8'hde;
  localparam logic [7:0] OFS_MASK        = 8'hdf;
  localparam logic [7:0] OFS_CON0        = 8'he4;
  localparam logic [7:0] OFS_CON1        = 8'he5;
  localparam logic [7:0] OFS_CON2        = 8'he6;
  localparam logic [7:0] OFS_FLAGS       = 8'he7;
  localparam logic [7:0] OFS_DATA        = 8'he8;
  localparam logic [7:0] OFS_GIE         = 8'he9;
  localparam logic [7:0] OFS_FLAGS_ALIAS = 8'hea;

  // card_control_0 fields
  localparam int unsigned B_DATA_RD_PTR_RST = 7;
  localparam int unsigned B_DATA_WR_PTR_RST = 6;
  localparam int unsigned B_RESP_RD_PTR_RST = 5;
  localparam int unsigned B_CMD_WR_PTR_RST  = 4;
  localparam int unsigned B_MULTI_BLOCK     = 3;
  localparam int unsigned B_BLOCK_FORMAT    = 2;
  localparam int unsigned B_SHORT_RESP      = 1;
  localparam int unsigned B_RESP_CRC_DIS    = 0;

  // card_control_1 fields
  localparam int unsigned B_BLOCK_LEN_HI    = 7;
  localparam int unsigned B_BLOCK_LEN_LO    = 4;
  localparam int unsigned B_WRITE_DIR       = 3;
  localparam int unsigned B_DATA_XFER_ARM   = 2;
  localparam int unsigned B_RESPONSE_ARM    = 1;
  localparam int unsigned B_CMD_SEND_ARM    = 0;

  // card_control_2 fields
  localparam int unsigned B_CTRL_CLK_EN     = 7;
  localparam int unsigned B_DATA_CTRL_RST   = 6;
  localparam int unsigned B_CMD_CTRL_RST    = 5;
  localparam int unsigned B_TX_DELAY_HI     = 2;
  localparam int unsigned B_TX_DELAY_LO     = 1;
  localparam int unsigned B_FLOW_GATE_EN    = 0;
  localparam logic [7:0]  CON2_WR_MASK      = 8'he7;

  // irq_flag_reg fields
  localparam int unsigned B_BUSY_CHANGE     = 7;
  localparam int unsigned B_RESPONSE_DONE   = 6;
  localparam int unsigned B_COMMAND_DONE    = 5;
  localparam int unsigned B_FRAME_DONE      = 4;
  localparam int unsigned B_HALF2_FULL      = 3;
  localparam int unsigned B_HALF1_FULL      = 2;
  localparam int unsigned B_HALF2_EMPTY     = 1;
  localparam int unsigned B_HALF1_EMPTY     = 0;
  localparam logic [7:0]  FLAG_RTC_MASK     = 8'hf0;
  localparam int unsigned B_GLOBAL_IRQ_EN   = 0;

  // reset values
  localparam logic [7:0] RST_CON0  = 8'h00;
  localparam logic [7:0] RST_CON1  = 8'h00;
  localparam logic [7:0] RST_CON2  = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h03;
  localparam logic [7:0] RST_MASK  = 8'hff;
  localparam logic [7:0] RST_GIE   = 8'h00;

  // data fifo geometry
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [3:0]  HALF_DEPTH = 4'h8;

  // transmit delay in card clock periods
  localparam logic [3:0] TX_DELAY_BASE = 4'h3;
  localparam logic [3:0] TX_DELAY_STEP = 4'h2;

  // card clock timing
  localparam int unsigned SYS_PERIOD_PS  = 5000;
  localparam int unsigned CARD_PERIOD_NS = 160;
  localparam int unsigned CARD_HALF_DIV  = (CARD_PERIOD_NS * 1000) / (2 * SYS_PERIOD_PS);

  // transfer configuration toward the line controllers
  typedef struct packed {
    logic        multiBlock;
    logic        blockFormat;
    logic        shortResp;
    logic        respCrcDisable;
    logic        writeDir;
    logic [11:0] blockBytes;
    logic        flowEnable;
  } chf_cfg_t;

  // one-cycle events from the line controllers
  typedef struct packed {
    logic busyChange;
    logic responseDone;
    logic commandDone;
    logic frameDone;
  } chf_evt_t;

  // reset levels toward pointers and controllers
  typedef struct packed {
    logic dataRdPtr;
    logic dataWrPtr;
    logic respRdPtr;
    logic cmdWrPtr;
    logic dataCtrl;
    logic cmdCtrl;
  } chf_rst_t;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b00,
    DLY_WAIT = 2'b01,
    DLY_GO   = 2'b11
  } chf_dly_t;

endpackage

// file: hdl/chf_flow_irq_ctrl.sv
`timescale 1ns/1ps

// Behaviour
// - transmit with flow gating: stop card clock when both halves empty
// - receive with flow gating: stop card clock when both halves full
// - stopped clock freezes card lines; data port access lets it resume
// - eight latched interrupt flags for card and fifo events
// - each flag has a mask bit; set mask blocks its request
// - interrupt when unmasked flag set and global enable set
// - reading flag register returns flags and clears read-to-clear ones
// - control 0 bits 7..4 hold four fifo pointers reset while set
// - control 0 bit 3 selects multi-block versus single-block
// - control 0 bit 2 selects block versus stream format
// - control 0 bit 1 selects 48-bit versus 136-bit responses
// - control 0 bit 0 disables response crc check
// - control 1 bit 3 selects host-to-card write direction
// - set then clear of control 1 bit 1 arms response reception
// - control 2 bit 7 runs card clock; clear freezes the controller
// - set then clear of control 2 bit 6 resets data controller
// - set then clear of control 2 bit 5 resets command controller
// - transmit delay after response is 3 plus 2 per step periods
// - control 2 flow enable bit turns fifo clock gating on
// - control 2 bits 4..3 always read zero
// - sixteen byte fifo built as two eight byte halves
// - block length in bytes is two to the programmed power, zero for powers 12 to 15
// - empty flags set on empty, cleared on full; both set at reset
module chf_flow_irq_ctrl #(
  parameter int unsigned HALF_DIV = chf_pkg::CARD_HALF_DIV
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // register port
  input  wire logic [7:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [7:0]       regRdata,
  // line controller side
  input  wire chf_pkg::chf_evt_t lineEvt,
  input  wire logic [5:0]       cardStatus,
  input  wire logic             xferActive,
  input  wire logic             lnkPush,
  input  wire logic [7:0]       lnkRxData,
  input  wire logic             lnkPop,
  output logic      [7:0]       lnkTxData,
  // card clock and control outputs
  output logic                  card_clock,
  output logic                  cardRise,
  output logic                  cardFall,
  output logic                  busFreeze,
  output logic                  ctrlFrozen,
  output chf_pkg::chf_cfg_t     cfg,
  output chf_pkg::chf_rst_t     resets,
  output logic                  responseArm,
  output logic                  dataXferArm,
  output logic                  commandSendArm,
  output logic                  dataTxGo,
  output logic                  irq
);
  import chf_pkg::*;

  // register state
  logic [7:0] con0Reg, con0Next;
  logic [7:0] con1Reg, con1Next;
  logic [7:0] con2Reg, con2Next;
  logic [7:0] maskReg, maskNext;
  logic [7:0] gieReg,  gieNext;
  logic [7:0] flagReg, flagNext;
  logic [7:0] rdataReg, rdataNext;
  logic [2:0] armReg, armNext;

  // fifo state
  logic [7:0] fifoMem [FIFO_DEPTH];
  logic [3:0] wrPtrReg, wrPtrNext;
  logic [3:0] rdPtrReg, rdPtrNext;
  logic [3:0] cntReg [2];
  logic [3:0] cntNext [2];
  logic [7:0] txDataReg, txDataNext;

  // card clock and delay state
  logic [15:0] divReg, divNext;
  logic        clkReg, clkNext;
  logic        riseReg, riseNext;
  logic        fallReg, fallNext;
  chf_dly_t    dlyReg, dlyNext;
  logic [3:0]  dlyCntReg, dlyCntNext;

  // decoded strobes
  logic wrCon0, wrCon1, wrCon2, wrMask, wrGie, flagRead;
  logic pushReq, popReq, pushOk, popOk, dataAccess;
  logic [7:0] pushData;
  logic writeDir, flowStop, cardRun;

  // one half's fill count after a push and a pop
  function automatic logic [3:0] halfCount(input logic [3:0] cnt,
                                           input logic       inc,
                                           input logic       dec);
    logic [3:0] res;
    res = cnt;
    if (inc && !dec) begin
      res = cnt + 4'h1;
    end else if (dec && !inc) begin
      res = cnt - 4'h1;
    end
    return res;
  endfunction

  // block length in bytes from its exponent
  function automatic logic [11:0] blockBytes(input logic [3:0] lenExp);
    return 12'h001 << lenExp;
  endfunction

  // address decode
  assign wrCon0   = regWr && (regAddr == OFS_CON0);
  assign wrCon1   = regWr && (regAddr == OFS_CON1);
  assign wrCon2   = regWr && (regAddr == OFS_CON2);
  assign wrMask   = regWr && (regAddr == OFS_MASK);
  assign wrGie    = regWr && (regAddr == OFS_GIE);
  assign flagRead = regRd && ((regAddr == OFS_FLAGS) || (regAddr == OFS_FLAGS_ALIAS));
  assign writeDir = con1Reg[B_WRITE_DIR];

  // software feeds fifo when writing to card, link feeds it otherwise
  assign dataAccess = (regWr || regRd) && (regAddr == OFS_DATA);
  assign pushReq    = writeDir ? (regWr && dataAccess) : lnkPush;
  assign popReq     = writeDir ? lnkPop : (regRd && dataAccess);
  assign pushData   = writeDir ? regWdata : lnkRxData;

  // control registers
  always_comb begin
    con0Next = con0Reg;
    con1Next = con1Reg;
    con2Next = con2Reg;
    maskNext = maskReg;
    gieNext  = gieReg;
    if (wrCon0) begin
      con0Next = regWdata;
    end
    if (wrCon1) begin
      con1Next = regWdata;
    end
    if (wrCon2) begin
      con2Next = regWdata & CON2_WR_MASK;
    end
    if (wrMask) begin
      maskNext = regWdata;
    end
    if (wrGie) begin
      gieNext = {7'h00, regWdata[B_GLOBAL_IRQ_EN]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      con0Reg <= RST_CON0;
      con1Reg <= RST_CON1;
      con2Reg <= RST_CON2;
      maskReg <= RST_MASK;
      gieReg  <= RST_GIE;
    end else begin
      con0Reg <= con0Next;
      con1Reg <= con1Next;
      con2Reg <= con2Next;
      maskReg <= maskNext;
      gieReg  <= gieNext;
    end
  end

  // arm pulses on the falling edge of a set-then-clear sequence
  always_comb begin
    armNext = 3'h0;
    if (wrCon1) begin
      armNext[0] = con1Reg[B_RESPONSE_ARM] && !regWdata[B_RESPONSE_ARM];
      armNext[1] = con1Reg[B_DATA_XFER_ARM] && !regWdata[B_DATA_XFER_ARM];
      armNext[2] = con1Reg[B_CMD_SEND_ARM] && !regWdata[B_CMD_SEND_ARM];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      armReg <= 3'h0;
    end else begin
      armReg <= armNext;
    end
  end

  assign responseArm    = armReg[0];
  assign dataXferArm    = armReg[1];
  assign commandSendArm = armReg[2];

  // pointer reset levels follow their bits
  assign resets.dataRdPtr = con0Reg[B_DATA_RD_PTR_RST];
  assign resets.dataWrPtr = con0Reg[B_DATA_WR_PTR_RST];
  assign resets.respRdPtr = con0Reg[B_RESP_RD_PTR_RST];
  assign resets.cmdWrPtr  = con0Reg[B_CMD_WR_PTR_RST];
  // controller resets held while the bit is one
  assign resets.dataCtrl  = con2Reg[B_DATA_CTRL_RST];
  assign resets.cmdCtrl   = con2Reg[B_CMD_CTRL_RST];

  assign cfg.multiBlock     = con0Reg[B_MULTI_BLOCK];
  assign cfg.blockFormat    = con0Reg[B_BLOCK_FORMAT];
  assign cfg.shortResp      = con0Reg[B_SHORT_RESP];
  assign cfg.respCrcDisable = con0Reg[B_RESP_CRC_DIS];
  assign cfg.writeDir       = writeDir;
  assign cfg.blockBytes     = blockBytes(con1Reg[B_BLOCK_LEN_HI:B_BLOCK_LEN_LO]);
  assign cfg.flowEnable     = con2Reg[B_FLOW_GATE_EN];

  // two eight byte halves, selected by pointer msb
  always_comb begin
    pushOk     = pushReq && (cntReg[wrPtrReg[3]] != HALF_DEPTH);
    popOk      = popReq && (cntReg[rdPtrReg[3]] != 4'h0);
    wrPtrNext  = pushOk ? wrPtrReg + 4'h1 : wrPtrReg;
    rdPtrNext  = popOk ? rdPtrReg + 4'h1 : rdPtrReg;
    cntNext[0] = halfCount(cntReg[0], pushOk && !wrPtrReg[3], popOk && !rdPtrReg[3]);
    cntNext[1] = halfCount(cntReg[1], pushOk && wrPtrReg[3], popOk && rdPtrReg[3]);
    txDataNext = (popOk && writeDir) ? fifoMem[rdPtrReg] : txDataReg;
    // pointer resets abort the fifo contents
    if (resets.dataRdPtr || resets.dataWrPtr || resets.dataCtrl) begin
      cntNext[0] = 4'h0;
      cntNext[1] = 4'h0;
    end
    if (resets.dataRdPtr || resets.dataCtrl) begin
      rdPtrNext = 4'h0;
    end
    if (resets.dataWrPtr || resets.dataCtrl) begin
      wrPtrNext = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtrReg  <= 4'h0;
      rdPtrReg  <= 4'h0;
      cntReg[0] <= 4'h0;
      cntReg[1] <= 4'h0;
      txDataReg <= 8'h00;
    end else begin
      wrPtrReg  <= wrPtrNext;
      rdPtrReg  <= rdPtrNext;
      cntReg[0] <= cntNext[0];
      cntReg[1] <= cntNext[1];
      txDataReg <= txDataNext;
    end
  end

  // fifo storage, written on an accepted push
  always_ff @(posedge sys_clk) begin
    if (pushOk) begin
      fifoMem[wrPtrReg] <= pushData;
    end
  end

  assign lnkTxData = txDataReg;

  // interrupt flags
  always_comb begin
    flagNext = flagReg;
    // a read clears the event flags, a new event wins
    if (flagRead) begin
      flagNext = flagReg & ~FLAG_RTC_MASK;
    end
    if (lineEvt.busyChange) begin
      flagNext[B_BUSY_CHANGE] = 1'b1;
    end
    if (lineEvt.responseDone) begin
      flagNext[B_RESPONSE_DONE] = 1'b1;
    end
    if (lineEvt.commandDone) begin
      flagNext[B_COMMAND_DONE] = 1'b1;
    end
    if (lineEvt.frameDone) begin
      flagNext[B_FRAME_DONE] = 1'b1;
    end
    // empty set on empty, cleared on full; full the reverse
    if (cntNext[0] == 4'h0) begin
      flagNext[B_HALF1_EMPTY] = 1'b1;
      flagNext[B_HALF1_FULL]  = 1'b0;
    end else if (cntNext[0] == HALF_DEPTH) begin
      flagNext[B_HALF1_EMPTY] = 1'b0;
      flagNext[B_HALF1_FULL]  = 1'b1;
    end
    if (cntNext[1] == 4'h0) begin
      flagNext[B_HALF2_EMPTY] = 1'b1;
      flagNext[B_HALF2_FULL]  = 1'b0;
    end else if (cntNext[1] == HALF_DEPTH) begin
      flagNext[B_HALF2_EMPTY] = 1'b0;
      flagNext[B_HALF2_FULL]  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flagReg <= RST_FLAGS;
    end else begin
      flagReg <= flagNext;
    end
  end

  // unmasked flag and global enable raise the request
  assign irq = gieReg[B_GLOBAL_IRQ_EN] && ((flagReg & ~maskReg) != 8'h00);

  // read data, one cycle after the strobe
  always_comb begin
    rdataNext = 8'h00;
    if (regRd) begin
      case (regAddr)
        OFS_STATUS:      rdataNext = {2'b00, cardStatus};
        OFS_MASK:        rdataNext = maskReg;
        OFS_CON0:        rdataNext = con0Reg;
        OFS_CON1:        rdataNext = con1Reg;
        OFS_CON2:        rdataNext = con2Reg & CON2_WR_MASK;
        // current flags returned in the clearing access
        OFS_FLAGS:       rdataNext = flagReg;
        OFS_FLAGS_ALIAS: rdataNext = flagReg;
        OFS_DATA:        rdataNext = popOk ? fifoMem[rdPtrReg] : 8'h00;
        OFS_GIE:         rdataNext = gieReg;
        default:         rdataNext = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdataReg <= 8'h00;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  assign regRdata = rdataReg;

  // flow gating from the half flags
  always_comb begin
    flowStop = 1'b0;
    if (con2Reg[B_FLOW_GATE_EN] && xferActive) begin
      if (writeDir) begin
        flowStop = flagReg[B_HALF1_EMPTY] && flagReg[B_HALF2_EMPTY];
      end else begin
        flowStop = flagReg[B_HALF1_FULL] && flagReg[B_HALF2_FULL];
      end
    end
  end

  // controller enable runs the card clock
  assign cardRun    = con2Reg[B_CTRL_CLK_EN] && !flowStop;
  assign ctrlFrozen = !con2Reg[B_CTRL_CLK_EN];
  // line controllers hold their lines while flow gating stops the clock
  assign busFreeze  = flowStop;

  // card clock divider, holds its level while flow gating stops it, driven low while control 2 bit 7 is clear
  always_comb begin
    divNext  = divReg;
    clkNext  = clkReg;
    riseNext = 1'b0;
    fallNext = 1'b0;
    if (!con2Reg[B_CTRL_CLK_EN]) begin
      divNext = 16'h0000;
      clkNext = 1'b0;
    // resumes once a port access has moved the half flags
    end else if (cardRun) begin
      if (divReg == 16'(HALF_DIV - 1)) begin
        divNext  = 16'h0000;
        clkNext  = !clkReg;
        riseNext = !clkReg;
        fallNext = clkReg;
      end else begin
        divNext = divReg + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      divReg  <= 16'h0000;
      clkReg  <= 1'b0;
      riseReg <= 1'b0;
      fallReg <= 1'b0;
    end else begin
      divReg  <= divNext;
      clkReg  <= clkNext;
      riseReg <= riseNext;
      fallReg <= fallNext;
    end
  end

  assign card_clock = clkReg;
  assign cardRise   = riseReg;
  assign cardFall   = fallReg;

  // transmit delay after a response, counted in card periods
  always_comb begin
    dlyNext    = dlyReg;
    dlyCntNext = dlyCntReg;
    case (dlyReg)
      DLY_IDLE: begin
        if (lineEvt.responseDone && writeDir) begin
          dlyNext    = DLY_WAIT;
          dlyCntNext = TX_DELAY_BASE
                     + TX_DELAY_STEP * {2'b00, con2Reg[B_TX_DELAY_HI:B_TX_DELAY_LO]};
        end
      end
      DLY_WAIT: begin
        if (riseReg) begin
          dlyCntNext = dlyCntReg - 4'h1;
          if (dlyCntReg == 4'h1) begin
            dlyNext = DLY_GO;
          end
        end
      end
      DLY_GO: begin
        dlyNext = DLY_IDLE;
      end
      default: begin
        dlyNext = DLY_IDLE;
      end
    endcase
    // data controller reset aborts the wait
    if (resets.dataCtrl) begin
      dlyNext    = DLY_IDLE;
      dlyCntNext = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dlyReg    <= DLY_IDLE;
      dlyCntReg <= 4'h0;
    end else begin
      dlyReg    <= dlyNext;
      dlyCntReg <= dlyCntNext;
    end
  end

  assign dataTxGo = (dlyReg == DLY_GO);

endmodule

// file: test/chf_flow_irq_ctrl_monitor.sv
`timescale 1ns/1ps
module chf_flow_irq_ctrl_monitor (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // register port
  input wire logic [7:0]        regAddr,
  input wire logic [7:0]        regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [7:0]        regRdata,
  // line and card side
  input wire chf_pkg::chf_evt_t lineEvt,
  input wire logic              xferActive,
  input wire logic              card_clock,
  input wire logic              cardRise,
  input wire logic              busFreeze,
  input wire logic              ctrlFrozen,
  input wire chf_pkg::chf_cfg_t cfg,
  input wire chf_pkg::chf_rst_t resets,
  input wire logic              responseArm,
  input wire logic              dataTxGo,
  input wire logic              irq
);
  import chf_pkg::*;
  logic       pWr_reg;
  logic [7:0] pAd_reg;
  logic [7:0] pData_reg;
  // last write seen, so outputs can be tied to it
  always_ff @(posedge sys_clk) begin
    pWr_reg   <= regWr && !rst;
    pAd_reg   <= regAddr;
    pData_reg <= regWdata;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_frzCause;
    busFreeze |-> cfg.flowEnable && xferActive;
  endproperty
  a_frzCause: assert property (p_frzCause) else $error("freeze without cause");
  property p_frzHold;
    busFreeze |=> $stable(card_clock) && !cardRise;
  endproperty
  a_frzHold: assert property (p_frzHold) else $error("clock moved while frozen");
  property p_frozen;
    ctrlFrozen ##1 ctrlFrozen |-> !card_clock;
  endproperty
  a_frozen: assert property (p_frozen) else $error("clock runs while disabled");
  property p_con0;
    pWr_reg && pAd_reg == OFS_CON0 |->
      {resets.dataRdPtr, resets.dataWrPtr, resets.respRdPtr, resets.cmdWrPtr, cfg.multiBlock,
       cfg.blockFormat, cfg.shortResp, cfg.respCrcDisable} == pData_reg;
  endproperty
  a_con0: assert property (p_con0) else $error("control 0 outputs wrong");
  property p_blk;
    pWr_reg && pAd_reg == OFS_CON1 && pData_reg[7:4] <= 4'hb |->
      cfg.blockBytes == 12'h001 << pData_reg[7:4] && cfg.writeDir == pData_reg[3];
  endproperty
  a_blk: assert property (p_blk) else $error("block length or direction wrong");
  property p_con2;
    pWr_reg && pAd_reg == OFS_CON2 |-> resets.dataCtrl == pData_reg[6] &&
      resets.cmdCtrl == pData_reg[5] && ctrlFrozen == !pData_reg[7];
  endproperty
  a_con2: assert property (p_con2) else $error("control 2 outputs wrong");
  property p_arm;
    responseArm |-> pWr_reg && pAd_reg == OFS_CON1 && !pData_reg[1];
  endproperty
  a_arm: assert property (p_arm) else $error("response arm without clearing write");
  property p_rtc;
    (regRd && regAddr == OFS_FLAGS && lineEvt == 4'h0) ##1 (regRd && regAddr == OFS_FLAGS)
      |=> regRdata[7:4] == 4'h0;
  endproperty
  a_rtc: assert property (p_rtc) else $error("flags survive a read");
  property p_irqOff;
    pWr_reg && (pAd_reg == OFS_GIE && !pData_reg[0] || pAd_reg == OFS_MASK && pData_reg == 8'hff)
      |-> !irq;
  endproperty
  a_irqOff: assert property (p_irqOff) else $error("request despite mask or enable");
  property p_txGo;
    dataTxGo |-> $past(cardRise);
  endproperty
  a_txGo: assert property (p_txGo) else $error("transmit start off card edge");
endmodule

bind chf_flow_irq_ctrl chf_flow_irq_ctrl_monitor chf_flow_irq_ctrl_monitor_inst (.*);

// file: test/chf_card_model.sv
`timescale 1ns/1ps
module chf_card_model (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // card side
  input  wire logic              card_clock,
  input  wire chf_pkg::chf_cfg_t cfg,
  input  wire logic              cardActive,
  output logic                   xferActive,
  output logic                   lnkPush,
  output logic [7:0]             lnkRxData,
  output logic                   lnkPop
);
  import chf_pkg::*;
  logic       seen_reg;
  logic [7:0] byte_reg;
  logic       cardEdge;
  logic       rxByte;
  assign xferActive = cardActive;
  assign cardEdge   = !rst && cardActive && card_clock && !seen_reg;
  assign rxByte     = cardEdge && !cfg.writeDir;
  always @(posedge sys_clk) begin
    seen_reg  <= card_clock;
    lnkPop    <= cardEdge && cfg.writeDir;
    lnkPush   <= rxByte;
    // released data line shows the inverse between bytes
    lnkRxData <= rst ? 8'h00 : (rxByte ? byte_reg : ~lnkRxData);
    byte_reg  <= rst ? 8'ha0 : (rxByte ? byte_reg + 8'h01 : byte_reg);
  end
endmodule

// file: test/chf_flow_irq_ctrl_tb_top.sv
`timescale 1ns/1ps
module chf_flow_irq_ctrl_tb_top;
  import chf_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  chf_evt_t   lineEvt = '0;
  logic [5:0] cardStatus = 6'h2a;
  logic       cardActive = 1'b0;
  logic [7:0] regRdata, lnkRxData, lnkTxData, rv;
  logic       xferActive, lnkPush, lnkPop, card_clock, cardRise, cardFall, busFreeze;
  logic       ctrlFrozen, responseArm, dataXferArm, commandSendArm, dataTxGo, irq;
  chf_cfg_t   cfg;
  chf_rst_t   resets;
  int         nFail = 0;
  int         testsRun = 0;

  // clock and instances
  always #2.5 sys_clk = ~sys_clk;
  chf_flow_irq_ctrl chf_flow_irq_ctrl_inst (.*);
  chf_card_model chf_card_model_inst (.*);

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    rv = regRdata;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, rv, e);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_reset();
    rdc("con0", OFS_CON0, 8'h00);
    rdc("con1", OFS_CON1, 8'h00);
    rdc("con2", OFS_CON2, 8'h00);
    rdc("mask", OFS_MASK, 8'hff);
    rdc("gie", OFS_GIE, 8'h00);
    rdc("flags", OFS_FLAGS, 8'h03);
    rdc("status", OFS_STATUS, 8'h2a);
    rdc("unmapped", 8'h00, 8'h00);
    chk("frozen", ctrlFrozen, 1'b1);
  endtask

  task automatic t_config();
    wr(OFS_CON0, 8'ha5);
    chk("ptr", {resets.dataRdPtr, resets.dataWrPtr, resets.respRdPtr, resets.cmdWrPtr}, 4'ha);
    chk("fmt", {cfg.multiBlock, cfg.blockFormat, cfg.shortResp, cfg.respCrcDisable}, 4'h5);
    wr(OFS_CON0, 8'h5a);
    rdc("con0", OFS_CON0, 8'h5a);
    wr(OFS_CON0, 8'h00);
    chk("ptr rel", {resets.dataRdPtr, resets.dataWrPtr, resets.respRdPtr, resets.cmdWrPtr}, 4'h0);
    for (int b = 0; b < 12; b++) begin
      wr(OFS_CON1, {b[3:0], 4'h8});
      chk("blk bytes", cfg.blockBytes, 12'h001 << b);
    end
    chk("dir", cfg.writeDir, 1'b1);
    wr(OFS_CON2, 8'hff);
    rdc("con2", OFS_CON2, 8'he7);
    chk("ctl", {resets.dataCtrl, resets.cmdCtrl, cfg.flowEnable, ctrlFrozen}, 4'he);
    wr(OFS_CON2, 8'h00);
    chk("ctl rel", {resets.dataCtrl, resets.cmdCtrl, ctrlFrozen}, 3'h1);
    tick(40);
    chk("clk off", card_clock, 1'b0);
    wr(OFS_CON1, 8'h07);
    wr(OFS_CON1, 8'h00);
    chk("arms", {responseArm, dataXferArm, commandSendArm}, 3'h7);
    tick(1);
    chk("arms end", {responseArm, dataXferArm, commandSendArm}, 3'h0);
  endtask

  task automatic t_irq();
    logic [7:0] saved;
    wr(OFS_MASK, 8'h00);
    wr(OFS_GIE, 8'h01);
    chk("irq empty", irq, 1'b1);
    wr(OFS_MASK, 8'h03);
    chk("irq masked", irq, 1'b0);
    for (int b = 0; b < 4; b++) begin
      lineEvt <= chf_evt_t'(4'h1 << b);
      tick(1);
      lineEvt <= '0;
      chk("irq evt", irq, 1'b1);
      rd(OFS_FLAGS);
      saved = rv;
      rd(OFS_FLAGS);
      chk("flag set", saved, 8'h03 | (8'h10 << b));
      chk("flag clr", rv, 8'h03);
      chk("irq ack", irq, 1'b0);
    end
    wr(OFS_MASK, 8'hff);
    lineEvt <= 4'h1;
    tick(1);
    lineEvt <= '0;
    chk("irq mask", irq, 1'b0);
    wr(OFS_MASK, 8'h00);
    chk("irq unmask", irq, 1'b1);
    wr(OFS_GIE, 8'h00);
    chk("irq gie", irq, 1'b0);
    rdc("flags ack", OFS_FLAGS, 8'h13);
  endtask

  task automatic t_delay();
    int n;
    wr(OFS_CON1, 8'h08);
    for (int d = 0; d < 4; d++) begin
      wr(OFS_CON2, 8'h80 | (d[7:0] << 1));
      lineEvt <= 4'h4;
      tick(1);
      lineEvt <= '0;
      n = 0;
      repeat (400) begin
        if (dataTxGo) break;
        n += cardRise;
        tick(1);
      end
      chk("tx delay", n, 3 + 2 * d);
    end
  endtask

  task automatic t_tx();
    logic c;
    wr(OFS_CON2, 8'h81);
    cardActive <= 1'b1;
    tick(2);
    chk("tx stop", busFreeze, 1'b1);
    c = card_clock;
    tick(64);
    chk("tx hold", {card_clock, cardFall}, {c, 1'b0});
    for (int i = 0; i < 8; i++) wr(OFS_DATA, 8'h10 + i[7:0]);
    tick(1);
    chk("tx run", busFreeze, 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (100) begin
        if (lnkPop) break;
        tick(1);
      end
      tick(1);
      chk("tx byte", lnkTxData, 8'h10 + i);
    end
    tick(2);
    chk("tx drained", busFreeze, 1'b1);
    cardActive <= 1'b0;
  endtask

  task automatic t_rx();
    wr(OFS_CON1, 8'h00);
    rd(OFS_FLAGS);
    cardActive <= 1'b1;
    repeat (1000) begin
      if (busFreeze) break;
      tick(1);
    end
    rdc("rx full", OFS_FLAGS, 8'h0c);
    chk("rx stop", busFreeze, 1'b1);
    for (int i = 0; i < 16; i++) begin
      rdc("rx byte", OFS_DATA, 8'ha0 + i);
      if (i == 8) chk("rx run", busFreeze, 1'b0);
    end
    cardActive <= 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_config();
    t_irq();
    t_delay();
    t_tx();
    t_rx();
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    final_report();
  end
endmodule
